// file: hdl/ext_cfg_pkg.sv
package ext_cfg_pkg;

	// byte offsets inside configuration space
	localparam logic [11:0] OFF_INT_STATE = 12'h0F4;
	localparam logic [11:0] OFF_IND_ADDR = 12'h0F8;
	localparam logic [11:0] OFF_IND_WIN = 12'h0FC;
	localparam logic [11:0] OFF_VC_HDR = 12'h100;
	localparam logic [11:0] OFF_VC_CAP1 = 12'h104;

	// address register fields, write mask and register reset values
	localparam int REG_NUM_LSB = 2;
	localparam int REG_NUM_MSB = 7;
	localparam int EXT_NUM_LSB = 8;
	localparam int EXT_NUM_MSB = 11;
	localparam logic [31:0] ADDR_WR_MASK = 32'h0000_0FFC;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [31:0] INT_STATE_RESET = 32'h0000_0000;

	// capability constants
	localparam logic [15:0] CAP_ID_VAL = 16'h0002;
	localparam logic [3:0] CAP_VER_VAL = 4'h1;
	localparam logic [11:0] NEXT_PTR_VAL = 12'h000;
	localparam logic [2:0] EXTRA_VC_VAL = 3'h0;
	localparam logic [2:0] LP_VC_VAL = 3'h0;
	localparam logic [1:0] ARB_TIME_BASE_VAL = 2'h0;
	localparam logic [1:0] ARB_ENTRY_SIZE_VAL = 2'h1;

	localparam logic [31:0] VC_HDR_WORD = {NEXT_PTR_VAL, CAP_VER_VAL,
		CAP_ID_VAL};
	localparam logic [31:0] VC_CAP1_WORD = {20'h00000, ARB_ENTRY_SIZE_VAL,
		ARB_TIME_BASE_VAL, 1'b0, LP_VC_VAL, 1'b0, EXTRA_VC_VAL};

	typedef enum logic [0:0] {ST_IDLE, ST_EXT} acc_state_e;

	// expand four byte enables into a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	// merge written bytes into a word, only writable bits change
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be,
		input logic [31:0] wmask);
		logic [31:0] m;
		m = be_mask(be) & wmask;
		be_merge = (old & ~m) | (wdata & m);
	endfunction : be_merge

endpackage : ext_cfg_pkg

// file: hdl/ind_addr_latch.sv
`timescale 1ns/1ps
module ind_addr_latch (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// write strobe with data
	input wire logic wr_en,
	input wire logic [3:0] wr_be,
	input wire logic [31:0] wr_data,
	// held address word
	output logic [31:0] addr_word
);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addr_word <= ext_cfg_pkg::ADDR_RESET;
		end else if (wr_en) begin
			addr_word <= ext_cfg_pkg::be_merge(addr_word, wr_data, wr_be,
				ext_cfg_pkg::ADDR_WR_MASK);
		end
	end

endmodule : ind_addr_latch

// file: hdl/ext_config_indirect_access.sv
`timescale 1ns/1ps
module ext_config_indirect_access (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// configuration requests
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic cfg_from_smbus,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	// aggregated legacy interrupt levels
	input wire logic [3:0] intx_state_in,
	// rest of configuration space
	output logic ext_req,
	output logic ext_write,
	output logic [11:0] ext_addr,
	output logic [3:0] ext_be,
	output logic [31:0] ext_wdata,
	input wire logic ext_ack,
	input wire logic [31:0] ext_rdata
);

	ext_cfg_pkg::acc_state_e state;
	logic [3:0] int_state;
	logic [31:0] ind_addr;
	logic [11:0] tgt;
	logic take;
	logic hit_addr;
	logic hit_win;
	logic win_ok;
	logic tgt_local;
	logic go_ext;
	logic addr_wr_en;

	// registers held by this slice
	function automatic logic is_local(input logic [11:0] idx);
		is_local = (idx == ext_cfg_pkg::OFF_INT_STATE) ||
			(idx == ext_cfg_pkg::OFF_IND_ADDR) ||
			(idx == ext_cfg_pkg::OFF_IND_WIN) ||
			(idx == ext_cfg_pkg::OFF_VC_HDR) ||
			(idx == ext_cfg_pkg::OFF_VC_CAP1);
	endfunction : is_local

	// read view of the local registers; the window reads zero here
	// so a window aimed at itself cannot recurse
	function automatic logic [31:0] local_read(input logic [11:0] idx,
		input logic [31:0] ia, input logic [3:0] ist);
		case (idx)
			ext_cfg_pkg::OFF_INT_STATE: local_read = {28'h0000000, ist};
			ext_cfg_pkg::OFF_IND_ADDR:
				local_read = ia & ext_cfg_pkg::ADDR_WR_MASK;
			ext_cfg_pkg::OFF_VC_HDR: local_read = ext_cfg_pkg::VC_HDR_WORD;
			ext_cfg_pkg::OFF_VC_CAP1: local_read = ext_cfg_pkg::VC_CAP1_WORD;
			default: local_read = 32'h0000_0000;
		endcase
	endfunction : local_read

	assign take = cfg_req && (state == ext_cfg_pkg::ST_IDLE);
	assign hit_addr = (cfg_addr == ext_cfg_pkg::OFF_IND_ADDR);
	assign hit_win = (cfg_addr == ext_cfg_pkg::OFF_IND_WIN);
	assign tgt = {ind_addr[ext_cfg_pkg::EXT_NUM_MSB:
		ext_cfg_pkg::REG_NUM_LSB], 2'b00};
	assign win_ok = hit_win && !cfg_from_smbus;
	assign tgt_local = is_local(tgt);
	assign go_ext = take && win_ok && !tgt_local;
	assign addr_wr_en = take && cfg_write && (hit_addr ||
		(win_ok && (tgt == ext_cfg_pkg::OFF_IND_ADDR)));

	ind_addr_latch u_addr (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(addr_wr_en),
		.wr_be(cfg_be),
		.wr_data(cfg_wdata),
		.addr_word(ind_addr)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_state <= ext_cfg_pkg::INT_STATE_RESET[3:0];
		end else begin
			int_state <= intx_state_in;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ext_cfg_pkg::ST_IDLE;
		end else begin
			case (state)
				ext_cfg_pkg::ST_IDLE: begin
					if (go_ext) begin
						state <= ext_cfg_pkg::ST_EXT;
					end
				end
				ext_cfg_pkg::ST_EXT: begin
					if (ext_ack) begin
						state <= ext_cfg_pkg::ST_IDLE;
					end
				end
				default: state <= ext_cfg_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ext_req <= 1'b0;
			ext_write <= 1'b0;
			ext_addr <= 12'h000;
			ext_be <= 4'h0;
			ext_wdata <= 32'h0000_0000;
		end else begin
			ext_req <= go_ext;
			if (go_ext) begin
				ext_write <= cfg_write;
				ext_addr <= tgt;
				ext_be <= cfg_be;
				ext_wdata <= cfg_wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_ack <= 1'b0;
			if (take && !go_ext) begin
				cfg_ack <= 1'b1;
				if (cfg_write) begin
					cfg_rdata <= 32'h0000_0000;
				end else if (hit_win) begin
					cfg_rdata <= win_ok ?
						local_read(tgt, ind_addr, int_state) : 32'h0000_0000;
				end else begin
					cfg_rdata <= local_read(cfg_addr, ind_addr, int_state);
				end
			end else if ((state == ext_cfg_pkg::ST_EXT) && ext_ack) begin
				cfg_ack <= 1'b1;
				cfg_rdata <= ext_write ? 32'h0000_0000 : ext_rdata;
			end
		end
	end

	// checks

	sequence s_rd(logic [11:0] a);
		take && !cfg_write && (cfg_addr == a);
	endsequence

	// forwarded access closing, target has answered
	sequence s_win_out;
		(state == ext_cfg_pkg::ST_EXT) && ext_ack;
	endsequence

	property p_int_sample;
		@(posedge clk_sys) disable iff (rst)
		##1 (int_state == $past(intx_state_in));
	endproperty
	a_int_sample: assert property (p_int_sample)
		else $error("interrupt state does not follow input");

	property p_int_read;
		@(posedge clk_sys) disable iff (rst)
		s_rd(ext_cfg_pkg::OFF_INT_STATE) |=>
			cfg_ack && (cfg_rdata == {28'h0000000, $past(int_state)});
	endproperty
	a_int_read: assert property (p_int_read)
		else $error("interrupt state read wrong");

	property p_addr_full;
		@(posedge clk_sys) disable iff (rst)
		(take && cfg_write && hit_addr && (cfg_be == 4'hF)) |=>
			(ind_addr == ($past(cfg_wdata) & ext_cfg_pkg::ADDR_WR_MASK));
	endproperty
	a_addr_full: assert property (p_addr_full)
		else $error("address register write wrong");

	property p_addr_be;
		@(posedge clk_sys) disable iff (rst)
		(take && cfg_write && hit_addr && !cfg_be[1]) |=>
			(ind_addr[11:8] == $past(ind_addr[11:8]));
	endproperty
	a_addr_be: assert property (p_addr_be)
		else $error("disabled byte written");

	property p_self_point;
		@(posedge clk_sys) disable iff (rst)
		(take && cfg_write && hit_addr && (cfg_be == 4'hF) &&
			(tgt == ext_cfg_pkg::OFF_IND_WIN) &&
			((cfg_wdata & ext_cfg_pkg::ADDR_WR_MASK) != ind_addr)) |=>
			!$stable(ind_addr);
	endproperty
	a_self_point: assert property (p_self_point)
		else $error("address write lost while aimed at window");

	property p_win_read;
		@(posedge clk_sys) disable iff (rst)
		(go_ext && !cfg_write) |=> ext_req && !ext_write &&
			(ext_addr == $past(tgt)) && !cfg_ack;
	endproperty
	a_win_read: assert property (p_win_read)
		else $error("window read not forwarded");

	property p_win_write;
		@(posedge clk_sys) disable iff (rst)
		(go_ext && cfg_write) |=> ext_write &&
			(ext_wdata == $past(cfg_wdata)) && (ext_be == $past(cfg_be));
	endproperty
	a_win_write: assert property (p_win_write)
		else $error("window write not forwarded");

	property p_ext_done;
		@(posedge clk_sys) disable iff (rst)
		s_win_out ##0 !ext_write |=>
			cfg_ack && (cfg_rdata == $past(ext_rdata));
	endproperty
	a_ext_done: assert property (p_ext_done)
		else $error("window read data not returned");

	property p_smbus;
		@(posedge clk_sys) disable iff (rst)
		(take && hit_win && cfg_from_smbus) |=> cfg_ack &&
			(cfg_rdata == 32'h0000_0000) && !ext_req && $stable(ind_addr);
	endproperty
	a_smbus: assert property (p_smbus)
		else $error("smbus window access had effect");

	property p_hdr;
		@(posedge clk_sys) disable iff (rst)
		s_rd(ext_cfg_pkg::OFF_VC_HDR) |=>
			(cfg_rdata[15:0] == 16'h0002) && (cfg_rdata[19:16] == 4'h1) &&
			(cfg_rdata[31:20] == 12'h000);
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("capability header read wrong");

	property p_cap1;
		@(posedge clk_sys) disable iff (rst)
		s_rd(ext_cfg_pkg::OFF_VC_CAP1) |=>
			(cfg_rdata[2:0] == 3'h0) && (cfg_rdata[6:4] == 3'h0) &&
			(cfg_rdata[9:8] == 2'h0) && (cfg_rdata[11:10] == 2'h1);
	endproperty
	a_cap1: assert property (p_cap1)
		else $error("port capability read wrong");

	property p_rsv;
		@(posedge clk_sys) disable iff (rst)
		s_rd(ext_cfg_pkg::OFF_IND_ADDR) |=>
			(cfg_rdata[31:12] == 20'h00000) && (cfg_rdata[1:0] == 2'h0);
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved address bits read nonzero");

	property p_rsv_held;
		@(posedge clk_sys) disable iff (rst)
		(ind_addr[31:12] == 20'h00000) && (ind_addr[1:0] == 2'h0);
	endproperty
	a_rsv_held: assert property (p_rsv_held)
		else $error("reserved address bits set");

	property p_ro_write;
		@(posedge clk_sys) disable iff (rst)
		(take && cfg_write && !hit_addr && !hit_win) |=>
			$stable(ind_addr) && cfg_ack && !ext_req;
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write to read-only register had effect");

	property p_unmapped;
		@(posedge clk_sys) disable iff (rst)
		(take && !cfg_write && !is_local(cfg_addr)) |=>
			cfg_ack && (cfg_rdata == 32'h0000_0000);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_wr_rdata;
		@(posedge clk_sys) disable iff (rst)
		(take && cfg_write && !go_ext) |=>
			cfg_ack && (cfg_rdata == 32'h0000_0000);
	endproperty
	a_wr_rdata: assert property (p_wr_rdata)
		else $error("local write answer wrong");

	property p_ext_wr_done;
		@(posedge clk_sys) disable iff (rst)
		s_win_out ##0 ext_write |=>
			cfg_ack && (cfg_rdata == 32'h0000_0000);
	endproperty
	a_ext_wr_done: assert property (p_ext_wr_done)
		else $error("window write not answered");

	// fields must not move while the target works on them
	property p_ext_hold;
		@(posedge clk_sys) disable iff (rst)
		(state == ext_cfg_pkg::ST_EXT) |=> !ext_req &&
			$stable(ext_addr) && $stable(ext_be) &&
			$stable(ext_wdata) && $stable(ext_write);
	endproperty
	a_ext_hold: assert property (p_ext_hold)
		else $error("forwarded access changed while open");

	property p_win_rd_be;
		@(posedge clk_sys) disable iff (rst)
		(go_ext && !cfg_write) |=> (ext_be == $past(cfg_be));
	endproperty
	a_win_rd_be: assert property (p_win_rd_be)
		else $error("window read byte enables lost");

	property p_win_local_rd;
		@(posedge clk_sys) disable iff (rst)
		(take && !cfg_write && win_ok &&
			(tgt == ext_cfg_pkg::OFF_VC_HDR)) |=>
			cfg_ack && (cfg_rdata == ext_cfg_pkg::VC_HDR_WORD);
	endproperty
	a_win_local_rd: assert property (p_win_local_rd)
		else $error("window read of local register wrong");

	property p_self_rd;
		@(posedge clk_sys) disable iff (rst)
		(take && !cfg_write && win_ok &&
			(tgt == ext_cfg_pkg::OFF_IND_WIN)) |=>
			cfg_ack && (cfg_rdata == 32'h0000_0000);
	endproperty
	a_self_rd: assert property (p_self_rd)
		else $error("window aimed at itself read nonzero");

	property p_win_addr_wr;
		@(posedge clk_sys) disable iff (rst)
		(take && cfg_write && win_ok && (cfg_be == 4'hF) &&
			(tgt == ext_cfg_pkg::OFF_IND_ADDR)) |=>
			(ind_addr == ($past(cfg_wdata) & ext_cfg_pkg::ADDR_WR_MASK));
	endproperty
	a_win_addr_wr: assert property (p_win_addr_wr)
		else $error("window write to address register lost");

endmodule : ext_config_indirect_access

// file: testbench/cfg_space_model.sv
`timescale 1ns/1ps
module cfg_space_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// forwarded access
	input wire logic ext_req,
	input wire logic ext_write,
	input wire logic [11:0] ext_addr,
	input wire logic [3:0] ext_be,
	input wire logic [31:0] ext_wdata,
	output logic ext_ack,
	output logic [31:0] ext_rdata,
	// answer latency in cycles, at least 1
	input wire logic [3:0] lat
);
	logic [31:0] mem [0:1023];
	logic [3:0] cnt;
	logic busy;
	int n_req;
	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = 32'h0;
		n_req = 0;
	end
	// rdata is scrambled outside the ack cycle so stale data never matches
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			ext_ack <= 1'b0;
			ext_rdata <= 32'h0;
		end else begin
			ext_ack <= 1'b0;
			ext_rdata <= ~ext_rdata;
			if (ext_req) begin
				n_req <= n_req + 1;
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt > 4'h1) begin
				cnt <= cnt - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				ext_ack <= 1'b1;
				ext_rdata <= mem[ext_addr[11:2]];
				for (int b = 0; b < 4; b++)
					if (ext_write && ext_be[b])
						mem[ext_addr[11:2]][b*8+:8] <= ext_wdata[b*8+:8];
			end
		end
	end
endmodule : cfg_space_model

// file: testbench/ext_config_indirect_access_tb.sv
`timescale 1ns/1ps
module ext_config_indirect_access_tb;
	logic clk_sys, rst, cfg_req, cfg_write, cfg_from_smbus, cfg_ack;
	logic [11:0] cfg_addr, ext_addr;
	logic [3:0] cfg_be, intx_state_in, ext_be, lat;
	logic [31:0] cfg_wdata, cfg_rdata, ext_wdata, ext_rdata;
	logic ext_req, ext_write, ext_ack;
	int fails, n_tests, cycles;

	ext_config_indirect_access ext_config_indirect_access_inst (
		.clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req),
		.cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_from_smbus(cfg_from_smbus),
		.cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.intx_state_in(intx_state_in), .ext_req(ext_req),
		.ext_write(ext_write), .ext_addr(ext_addr), .ext_be(ext_be),
		.ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

	cfg_space_model cfg_space_model_inst (
		.clk_sys(clk_sys), .rst(rst), .ext_req(ext_req),
		.ext_write(ext_write), .ext_addr(ext_addr), .ext_be(ext_be),
		.ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
		.lat(lat));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// one request pulse, then a bounded wait for the answer
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [3:0] be, input logic [31:0] d, input logic smb,
		output logic [31:0] r);
		int i;
		@(negedge clk_sys);
		cfg_req = 1'b1;
		cfg_write = w;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		cfg_from_smbus = smb;
		@(negedge clk_sys);
		cfg_req = 1'b0;
		for (i = 0; i < 40 && cfg_ack !== 1'b1; i++) @(negedge clk_sys);
		chk("cfg_ack", 32'h1, {31'h0, cfg_ack});
		r = cfg_rdata;
	endtask : acc

	task automatic wr(input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] d, input logic smb);
		logic [31:0] r;
		acc(1'b1, a, be, d, smb, r);
		chk("wr_rdata", 32'h0, r);
	endtask : wr

	task automatic rd(input string n, input logic [11:0] a,
		input logic smb, input logic [31:0] e);
		logic [31:0] r;
		acc(1'b0, a, 4'hF, 32'h0, smb, r);
		chk(n, e, r);
	endtask : rd

	task automatic t_regs;
		rd("int_state", 12'h0F4, 1'b0, 32'h0);
		rd("addr_reset", 12'h0F8, 1'b0, 32'h0);
		rd("vc_hdr", 12'h100, 1'b0, 32'h0001_0002);
		rd("vc_cap1", 12'h104, 1'b0, 32'h0000_0400);
		rd("unmapped", 12'h0F0, 1'b0, 32'h0);
		wr(12'h100, 4'hF, 32'hFFFF_FFFF, 1'b0);
		wr(12'h104, 4'hF, 32'hFFFF_FFFF, 1'b0);
		wr(12'h0F4, 4'hF, 32'hFFFF_FFFF, 1'b0);
		rd("vc_hdr_ro", 12'h100, 1'b0, 32'h0001_0002);
		rd("vc_cap1_ro", 12'h104, 1'b0, 32'h0000_0400);
		rd("int_ro", 12'h0F4, 1'b0, 32'h0);
	endtask : t_regs

	task automatic t_intx;
		for (int v = 0; v < 16; v++) begin
			intx_state_in = v[3:0];
			rd("int_state", 12'h0F4, 1'b0, {28'h0, v[3:0]});
		end
		intx_state_in = 4'h0;
	endtask : t_intx

	task automatic t_addr;
		wr(12'h0F8, 4'hF, 32'hFFFF_FFFF, 1'b0);
		rd("addr_all", 12'h0F8, 1'b0, 32'h0000_0FFC);
		wr(12'h0F8, 4'h1, 32'h0, 1'b0);
		rd("addr_be0", 12'h0F8, 1'b0, 32'h0000_0F00);
		wr(12'h0F8, 4'h2, 32'h0, 1'b0);
		rd("addr_be1", 12'h0F8, 1'b0, 32'h0);
	endtask : t_addr

	task automatic t_window(input logic [3:0] l);
		lat = l;
		wr(12'h0F8, 4'hF, 32'h0000_0208, 1'b0);
		wr(12'h0FC, 4'hF, 32'h1234_5678, 1'b0);
		chk("ext_addr", 32'h208, {20'h0, ext_addr});
		chk("tgt_word", 32'h1234_5678, cfg_space_model_inst.mem[130]);
		rd("win_rd", 12'h0FC, 1'b0, 32'h1234_5678);
		wr(12'h0FC, 4'h5, 32'hAABB_CCDD, 1'b0);
		rd("win_be", 12'h0FC, 1'b0, 32'h12BB_56DD);
	endtask : t_window

	task automatic t_smbus;
		int n0;
		n0 = cfg_space_model_inst.n_req;
		rd("smb_rd", 12'h0FC, 1'b1, 32'h0);
		wr(12'h0FC, 4'hF, 32'hFFFF_FFFF, 1'b1);
		chk("smb_fwd", n0, cfg_space_model_inst.n_req);
		rd("smb_kept", 12'h0FC, 1'b0, 32'h12BB_56DD);
	endtask : t_smbus

	task automatic t_self;
		wr(12'h0F8, 4'hF, 32'h0000_00FC, 1'b0);
		rd("self_win", 12'h0FC, 1'b0, 32'h0);
		wr(12'h0F8, 4'hF, 32'h0000_0300, 1'b0);
		rd("addr_self", 12'h0F8, 1'b0, 32'h0000_0300);
		wr(12'h0F8, 4'hF, 32'h0000_0100, 1'b0);
		rd("win_hdr", 12'h0FC, 1'b0, 32'h0001_0002);
		wr(12'h0F8, 4'hF, 32'h0000_00F8, 1'b0);
		wr(12'h0FC, 4'hF, 32'h0000_0204, 1'b0);
		rd("win_addr", 12'h0F8, 1'b0, 32'h0000_0204);
	endtask : t_self

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// hang guard, the whole run needs well under 2000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		rst = 1'b1;
		{cfg_req, cfg_write, cfg_from_smbus} = 3'h0;
		cfg_addr = 12'h0;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		intx_state_in = 4'h0;
		lat = 4'h1;
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		t_regs();
		t_intx();
		t_addr();
		t_window(4'h1);
		t_window(4'h9);
		t_smbus();
		t_self();
		wrap_up();
	end
endmodule : ext_config_indirect_access_tb
